// File: i2cs_consts.svh
/*
  Constants of the two-wire slave transfer engine: register offsets, bit positions,
  reset values and frame counts. Assumes inclusion by bare name from design files.
*/
`ifndef I2CS_CONSTS_SVH
`define I2CS_CONSTS_SVH

`define I2CS_OFF_CTRL 8'h00
`define I2CS_OFF_STAT 8'h04
`define I2CS_OFF_DATA 8'h08
`define I2CS_OFF_MODE 8'h0c
`define I2CS_OFF_OWN 8'h10
`define I2CS_OFF_OWN2 8'h14
`define I2CS_OFF_XCTL 8'h18
`define I2CS_OFF_CLR 8'h1c

`define I2CS_CTRL_EN 7
`define I2CS_CTRL_IEN 6
`define I2CS_CTRL_BUSY 5
`define I2CS_CTRL_MSEL 4
`define I2CS_CTRL_TSEL 3
`define I2CS_CTRL_ACK_CAPTURE_ENABLE 2
`define I2CS_CTRL_IRQ 1
`define I2CS_CTRL_SSC 0

`define I2CS_STAT_STOP 7
`define I2CS_STAT_SECOND_ADDRESS_MATCH 6
`define I2CS_STAT_RXF 5
`define I2CS_STAT_TXE 4
`define I2CS_STAT_TEND 3
`define I2CS_STAT_ACK_BIT 0

`define I2CS_MODE_WAIT 6
`define I2CS_MODE_BOS 3
`define I2CS_XCTL_STOP_IRQ_MASK 0
`define I2CS_OWN_FS 0

`define I2CS_CLR_CODE 4'hf
`define I2CS_OWN_RST 8'h00
`define I2CS_CNT_ACK 4'h8
`define I2CS_CNT_END 4'h9

`endif

// File: i2cs_pkg.sv
/*
  Types of the two-wire slave transfer engine.
  Assumes nothing of its surroundings.
*/
package i2cs_pkg;
  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_addr = 5'h02,
    st_rx = 5'h04,
    st_tx = 5'h08,
    st_ign = 5'h10
  } i2cs_state_e;
endpackage

// File: i2cs_engine.sv
/*
  Slave transfer engine of a two-wire serial bus with an APB register slave.
  Assumes an external master that drives the bus clock and open-drain wires with
  pull-ups resolved outside; pins are asynchronous to pclk.
*/
`include "i2cs_consts.svh"

// Summary of operation
// [R1] Mismatched address: ignore bus until next start
// [R2] Eighth bit picks receive or transmit select
// [R3] Start condition sets bus busy flag
// [R4] Ninth clock drives stored ack bit
// [R5] Ninth clock rise sets irq flag
// [R6] Second address match also sets transfer end
// [R7] Ninth rise moves byte, sets receive full
// [R8] Stretch clock until data read in receive
// [R9] Stop clears busy, sets stop, maybe irq
// [R10] Read address acks, sets empty, stretches clock
// [R11] Data write loads shift register, flags again
// [R12] Transmit captures master ack into ack bit
// [R13] Buffered byte continues, else stretch clock
// [R14] Writing ack capture enable zero clears ack
// [R15] Dummy read with transmit cleared releases clock
// [R16] Wait bit and formats steer irq; stretch
// [R17] Pins pass two agreeing latches before use
// [R18] Forced init resets buffer flags, sequencer, pin drives
// [R19] Forced init keeps registers and bit counter
// [R20] Clear code not retained; written whole
// [R21] Clear mid transfer releases both pins
// [R22] Software recovery: init, stop, wait, init
module i2cs_engine (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq
);
  function automatic logic [7:0] order(input logic [7:0] b, input logic lsb);
    order = lsb ? {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]} : b;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `I2CS_OFF_CLR);
  endfunction

  // Synchroniser then noise canceler, bit 0 clock, bit 1 data
  logic [1:0] pin_in;
  logic [1:0] meta_reg, sync_reg, nc_reg, filt_reg, filt_d_reg;
  assign pin_in = {sda_i, scl_i};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg[g] <= 1'b1;
          sync_reg[g] <= 1'b1;
          nc_reg[g] <= 1'b1;
          filt_reg[g] <= 1'b1;
          filt_d_reg[g] <= 1'b1;
        end else begin
          meta_reg[g] <= pin_in[g];
          sync_reg[g] <= meta_reg[g];
          nc_reg[g] <= sync_reg[g];
          if (sync_reg[g] == nc_reg[g]) begin // R17
            filt_reg[g] <= nc_reg[g];
          end
          filt_d_reg[g] <= filt_reg[g];
        end
      end
    end
  endgenerate

  logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
  assign scl = filt_reg[0];
  assign sda = filt_reg[1];
  assign scl_rise = scl & ~filt_d_reg[0];
  assign scl_fall = ~scl & filt_d_reg[0];
  assign start_ev = scl & filt_d_reg[0] & ~sda & filt_d_reg[1];
  assign stop_ev = scl & filt_d_reg[0] & sda & ~filt_d_reg[1];

  // APB decode
  logic acc, wr_ctrl, wr_stat, wr_data, wr_mode, wr_own, wr_own2, wr_xctl, wr_clr, rd_data;
  assign acc = psel & penable;
  assign wr_ctrl = acc & pwrite & (paddr == `I2CS_OFF_CTRL);
  assign wr_stat = acc & pwrite & (paddr == `I2CS_OFF_STAT);
  assign wr_data = acc & pwrite & (paddr == `I2CS_OFF_DATA);
  assign wr_mode = acc & pwrite & (paddr == `I2CS_OFF_MODE);
  assign wr_own = acc & pwrite & (paddr == `I2CS_OFF_OWN);
  assign wr_own2 = acc & pwrite & (paddr == `I2CS_OFF_OWN2);
  assign wr_xctl = acc & pwrite & (paddr == `I2CS_OFF_XCTL);
  assign wr_clr = acc & pwrite & (paddr == `I2CS_OFF_CLR);
  assign rd_data = acc & ~pwrite & (paddr == `I2CS_OFF_DATA);
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped(paddr);

  // Software registers
  logic module_enable_reg, irq_enable_reg, master_select_reg, transmit_select_reg;
  logic ack_capture_enable_reg, start_stop_control_reg, bus_busy_flag_reg, irq_flag_reg;
  logic stop_flag_reg, transfer_end_flag_reg, ack_bit_reg, stop_irq_mask_reg;
  logic wait_insert_reg, bit_order_select_reg;
  logic [2:0] frame_bit_counter_reg;
  logic [7:0] own_address_reg, second_own_address_reg;

  // Sequencer state
  i2cs_pkg::i2cs_state_e state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_register_reg, receive_buffer_reg, transmit_buffer_reg;
  logic rx_full_flag_reg, tx_empty_flag_reg, tx_have_reg, hold_reg, wait_hold_reg;
  logic second_address_match_reg, sda_oe_reg;

  logic st_addr, st_rx, st_tx, ack_fall, nine_rise, end_fall, addr_hit, hit2;
  logic force_init, tsel_set, ev_wload, ev_wait, ev_ackcap, irq_set, irq_clr;
  assign st_addr = state_reg == i2cs_pkg::st_addr;
  assign st_rx = state_reg == i2cs_pkg::st_rx;
  assign st_tx = state_reg == i2cs_pkg::st_tx;
  assign ack_fall = scl_fall & (cnt_reg == `I2CS_CNT_ACK);
  assign nine_rise = scl_rise & (cnt_reg == `I2CS_CNT_ACK);
  assign end_fall = scl_fall & (cnt_reg == `I2CS_CNT_END);
  assign hit2 = (shift_register_reg[7:1] == second_own_address_reg[7:1])
    & ~second_own_address_reg[`I2CS_OWN_FS];
  assign addr_hit = (shift_register_reg[7:1] == own_address_reg[7:1]) | hit2;
  assign force_init = ~module_enable_reg | (wr_clr & (pwdata[3:0] == `I2CS_CLR_CODE)); // R20
  assign tsel_set = ack_fall & st_addr & addr_hit & shift_register_reg[0];
  assign ev_wload = wr_data & st_tx & hold_reg & ~tx_have_reg;
  assign ev_wait = ack_fall & wait_insert_reg & (st_rx | st_tx);
  assign ev_ackcap = nine_rise & st_tx & ack_capture_enable_reg;
  assign irq_clr = wr_ctrl & ~pwdata[`I2CS_CTRL_IRQ];
  assign irq_set = (nine_rise & (st_addr | st_rx | st_tx)) | ev_wload | ev_wait // R5 R16
    | (stop_ev & ~stop_irq_mask_reg); // R9

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_enable_reg <= 1'b0;
      irq_enable_reg <= 1'b0;
      master_select_reg <= 1'b0;
      ack_capture_enable_reg <= 1'b0;
      start_stop_control_reg <= 1'b0;
      stop_irq_mask_reg <= 1'b0;
      wait_insert_reg <= 1'b0;
      bit_order_select_reg <= 1'b0;
      frame_bit_counter_reg <= 3'h0;
      own_address_reg <= `I2CS_OWN_RST;
      second_own_address_reg <= `I2CS_OWN_RST;
    end else begin
      if (wr_ctrl) begin
        module_enable_reg <= pwdata[`I2CS_CTRL_EN];
        irq_enable_reg <= pwdata[`I2CS_CTRL_IEN];
        master_select_reg <= pwdata[`I2CS_CTRL_MSEL];
        ack_capture_enable_reg <= pwdata[`I2CS_CTRL_ACK_CAPTURE_ENABLE];
        start_stop_control_reg <= pwdata[`I2CS_CTRL_SSC];
      end
      if (wr_mode) begin
        wait_insert_reg <= pwdata[`I2CS_MODE_WAIT];
        bit_order_select_reg <= pwdata[`I2CS_MODE_BOS];
        frame_bit_counter_reg <= pwdata[2:0];
      end
      if (wr_own) own_address_reg <= pwdata[7:0];
      if (wr_own2) second_own_address_reg <= pwdata[7:0];
      if (wr_xctl) stop_irq_mask_reg <= pwdata[`I2CS_XCTL_STOP_IRQ_MASK];
    end
  end

  // Hardware-set flags; a set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_reg <= 1'b0;
      stop_flag_reg <= 1'b0;
      transfer_end_flag_reg <= 1'b0;
      bus_busy_flag_reg <= 1'b0;
      transmit_select_reg <= 1'b0;
    end else begin
      irq_flag_reg <= irq_set | (irq_flag_reg & ~irq_clr);
      stop_flag_reg <= stop_ev | (stop_flag_reg & ~(wr_stat & ~pwdata[`I2CS_STAT_STOP]));
      transfer_end_flag_reg <= (nine_rise & (st_addr | st_rx) & second_address_match_reg) // R6
        | (transfer_end_flag_reg & ~(wr_stat & ~pwdata[`I2CS_STAT_TEND]));
      if (start_ev) bus_busy_flag_reg <= 1'b1; // R3
      else if (stop_ev) bus_busy_flag_reg <= 1'b0; // R9
      if (tsel_set) transmit_select_reg <= 1'b1; // R2
      else if (wr_ctrl) transmit_select_reg <= pwdata[`I2CS_CTRL_TSEL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_bit_reg <= 1'b0;
    end else if (ev_ackcap) begin
      ack_bit_reg <= sda; // R12
    end else if (wr_ctrl & ~pwdata[`I2CS_CTRL_ACK_CAPTURE_ENABLE]) begin
      ack_bit_reg <= 1'b0; // R14
    end else if (wr_stat) begin
      ack_bit_reg <= pwdata[`I2CS_STAT_ACK_BIT];
    end
  end

  // Frame bit count survives forced init
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 4'h0;
    end else if (start_ev | end_fall) begin
      cnt_reg <= 4'h0;
    end else if (scl_rise & (cnt_reg < `I2CS_CNT_END)) begin
      cnt_reg <= cnt_reg + 4'h1; // R19
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= i2cs_pkg::st_idle;
      shift_register_reg <= 8'h00;
      receive_buffer_reg <= 8'h00;
      transmit_buffer_reg <= 8'h00;
      rx_full_flag_reg <= 1'b0;
      tx_empty_flag_reg <= 1'b0;
      tx_have_reg <= 1'b0;
      hold_reg <= 1'b0;
      wait_hold_reg <= 1'b0;
      second_address_match_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (force_init) begin
      state_reg <= i2cs_pkg::st_idle; // R18
      rx_full_flag_reg <= 1'b0;
      tx_empty_flag_reg <= 1'b0;
      tx_have_reg <= 1'b0;
      hold_reg <= 1'b0; // R21
      wait_hold_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (stop_ev) begin
      state_reg <= i2cs_pkg::st_idle;
      hold_reg <= 1'b0;
      wait_hold_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_ev) begin
      state_reg <= own_address_reg[`I2CS_OWN_FS] ? i2cs_pkg::st_rx : i2cs_pkg::st_addr; // R16
      second_address_match_reg <= 1'b0;
      hold_reg <= 1'b0;
      wait_hold_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      if (scl_rise & (cnt_reg < `I2CS_CNT_ACK) & ~st_tx) begin
        shift_register_reg <= {shift_register_reg[6:0], sda};
      end
      if (scl_fall & (cnt_reg != `I2CS_CNT_ACK) & (cnt_reg != `I2CS_CNT_END)
          & (cnt_reg != 4'h0) & st_tx) begin
        shift_register_reg <= {shift_register_reg[6:0], 1'b0};
        sda_oe_reg <= tx_have_reg & ~shift_register_reg[6];
      end
      if (ack_fall) begin
        if (st_addr & ~addr_hit) begin
          state_reg <= i2cs_pkg::st_ign; // R1
          sda_oe_reg <= 1'b0;
        end else if (st_addr) begin
          sda_oe_reg <= 1'b1; // R10
          second_address_match_reg <= hit2 & (shift_register_reg[7:1] != own_address_reg[7:1]);
        end else if (st_rx) begin
          sda_oe_reg <= ~ack_bit_reg; // R4
        end else begin
          sda_oe_reg <= 1'b0;
        end
        if (ev_wait) wait_hold_reg <= 1'b1; // R16
      end
      if (nine_rise & st_addr & shift_register_reg[0]) begin
        state_reg <= i2cs_pkg::st_tx;
        tx_empty_flag_reg <= 1'b1; // R10
        tx_have_reg <= 1'b0;
      end else if (nine_rise & (st_addr | st_rx)) begin
        state_reg <= i2cs_pkg::st_rx;
        receive_buffer_reg <= order(shift_register_reg, bit_order_select_reg); // R7
        rx_full_flag_reg <= 1'b1;
      end else if (nine_rise & st_tx) begin
        tx_have_reg <= ~tx_empty_flag_reg; // R13
        if (~tx_empty_flag_reg) begin
          shift_register_reg <= order(transmit_buffer_reg, bit_order_select_reg);
          tx_empty_flag_reg <= 1'b1;
        end
      end else if (rd_data) begin
        rx_full_flag_reg <= 1'b0; // R8
      end
      if (end_fall) begin
        hold_reg <= (st_rx & rx_full_flag_reg & ~rd_data) | (st_tx & ~tx_have_reg); // R8 R13
        sda_oe_reg <= st_tx & tx_have_reg & ~shift_register_reg[7];
      end else if (ev_wload) begin
        shift_register_reg <= order(pwdata[7:0], bit_order_select_reg); // R11
        tx_have_reg <= 1'b1;
        tx_empty_flag_reg <= 1'b1;
        hold_reg <= 1'b0;
        sda_oe_reg <= bit_order_select_reg ? ~pwdata[0] : ~pwdata[7];
      end else if (wr_data) begin
        transmit_buffer_reg <= pwdata[7:0];
        tx_empty_flag_reg <= 1'b0; // R11
      end else if (rd_data & hold_reg & (st_rx | ~transmit_select_reg)) begin
        hold_reg <= 1'b0; // R15
        if (st_tx) state_reg <= i2cs_pkg::st_ign;
      end
      if (irq_clr) wait_hold_reg <= 1'b0;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = hold_reg | wait_hold_reg;
  assign sda_oe = sda_oe_reg;
  assign irq = irq_flag_reg & irq_enable_reg; // R5

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        `I2CS_OFF_CTRL: prdata <= {24'h0, module_enable_reg, irq_enable_reg,
          bus_busy_flag_reg, master_select_reg, transmit_select_reg,
          ack_capture_enable_reg, irq_flag_reg, start_stop_control_reg};
        `I2CS_OFF_STAT: prdata <= {24'h0, stop_flag_reg, second_address_match_reg,
          rx_full_flag_reg, tx_empty_flag_reg, transfer_end_flag_reg, 2'h0, ack_bit_reg};
        `I2CS_OFF_DATA: prdata <= {24'h0, receive_buffer_reg};
        `I2CS_OFF_MODE: prdata <= {24'h0, 1'b0, wait_insert_reg, 2'h0,
          bit_order_select_reg, frame_bit_counter_reg};
        `I2CS_OFF_OWN: prdata <= {24'h0, own_address_reg};
        `I2CS_OFF_OWN2: prdata <= {24'h0, second_own_address_reg};
        `I2CS_OFF_XCTL: prdata <= {31'h0, stop_irq_mask_reg};
        default: prdata <= 32'h0;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  busy_on_start_a: assert property (start_ev |=> bus_busy_flag_reg) // R3
    else $error("busy flag not set after start");
  stop_flags_a: assert property (stop_ev |=> !bus_busy_flag_reg && stop_flag_reg) // R9
    else $error("stop did not clear busy or set stop");
  addr_ignore_a: assert property (ack_fall && st_addr && !addr_hit && !force_init
    && !stop_ev && !start_ev |=> state_reg == i2cs_pkg::st_ign && !sda_oe) // R1
    else $error("mismatched address not ignored");
  read_dir_a: assert property (tsel_set |=> transmit_select_reg) // R2
    else $error("read direction did not set transmit select");
  ack_drive_a: assert property (ack_fall && st_rx && module_enable_reg && !wr_clr
    && !stop_ev && !start_ev |=> sda_oe == !$past(ack_bit_reg)) // R4
    else $error("ack slot does not follow ack bit");
  rx_load_a: assert property (nine_rise && st_rx && !force_init && !stop_ev && !start_ev
    |=> rx_full_flag_reg && irq_flag_reg ##1 rx_full_flag_reg || rd_data) // R7
    else $error("received byte not flagged");
  rx_stretch_a: assert property (end_fall && st_rx && rx_full_flag_reg && !rd_data
    && !force_init && !stop_ev && !start_ev |=> scl_oe) // R8
    else $error("clock not held with receive full");
  init_release_a: assert property (force_init |=> !scl_oe && !sda_oe) // R21
    else $error("forced init left a pin driven");
  ack_capture_a: assert property (ev_ackcap |=> ack_bit_reg == $past(sda)) // R12
    else $error("master ack not captured");
  ack_clear_a: assert property (wr_ctrl && !pwdata[`I2CS_CTRL_ACK_CAPTURE_ENABLE] && !ev_ackcap
    |=> !ack_bit_reg) // R14
    else $error("ack bit not cleared");

  rx_frame_c: cover property (nine_rise && st_rx ##[1:400] rd_data && hold_reg);
  tx_frame_c: cover property (ev_wload ##[1:900] nine_rise && st_tx);
  stop_seen_c: cover property (start_ev ##[1:1000] stop_ev);
endmodule

// File: i2cs_mst.sv
/*
  Behavioural two-wire bus master for the slave engine bench.
  Assumes the bench resolves both open-drain wires with pull-ups.
*/
module i2cs_mst #(
  parameter int HALF = 20
) (
  input wire logic pclk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Release SCL, then wait out any stretch by the slave
  task automatic clk_high();
    int n;
    n = 0;
    scl_low <= 1'b0;
    wait_cyc(1);
    while (scl !== 1'b1 && n < 20000) begin
      wait_cyc(1);
      n++;
    end
    wait_cyc(HALF / 2);
  endtask
  task automatic xfer_bit(input logic b, output logic r);
    sda_low <= ~b;
    wait_cyc(HALF);
    clk_high();
    r = sda;
    wait_cyc(HALF / 2);
    scl_low <= 1'b1;
    wait_cyc(HALF / 2);
  endtask
  task automatic xfer_byte(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                           output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], q[i]);
    end
    xfer_bit(ack_in, ack_out);
  endtask
  task automatic start();
    sda_low <= 1'b1;
    wait_cyc(HALF);
    scl_low <= 1'b1;
    wait_cyc(HALF / 2);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    wait_cyc(HALF);
    clk_high();
    sda_low <= 1'b0;
    wait_cyc(HALF);
  endtask
  // Single-cycle SDA spike while SCL idles high
  task automatic glitch();
    sda_low <= 1'b1;
    wait_cyc(1);
    sda_low <= 1'b0;
  endtask
endmodule

// File: test_i2c_slave_transfer_engine.sv
/*
  Self-checking bench of the two-wire slave engine: APB software side and a
  behavioural bus master. Assumes the engine's hand-over timing.
*/
`include "i2cs_consts.svh"
module test_i2c_slave_transfer_engine;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr, r, d0, d1;
  logic [31:0] pwdata, prdata, q;
  logic scl_o, scl_oe, sda_o, sda_oe, scl_low, sda_low, ack;
  logic [6:0] own;
  logic [7:0] dat [4];
  int bad_count, check_count, seed, nb;
  wire scl = ~((scl_oe & ~scl_o) | scl_low);
  wire sda = ~((sda_oe & ~sda_o) | sda_low);
  i2cs_engine u_i2cs_engine (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  i2cs_mst #(.HALF(20)) u_i2cs_mst (.pclk(pclk), .scl(scl), .sda(sda), .scl_low(scl_low),
    .sda_low(sda_low));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  function automatic logic [7:0] rev(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rev[i] = b[7 - i];
    end
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    check(q[7:0] & m, e);
  endtask
  task automatic wait_oe(input logic v);
    int k;
    k = 0;
    while (scl_oe !== v && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    check({7'h0, scl_oe}, {7'h0, v});
  endtask
  task automatic serve_rx(input logic [7:0] e, input logic last);
    wait_oe(1'b1);
    repeat (30) @(posedge pclk);
    check({7'h0, scl_oe}, 8'h01);
    check({7'h0, irq}, 8'h01);
    rdc(`I2CS_OFF_CTRL, 8'h0a, 8'h02);
    rdc(`I2CS_OFF_STAT, 8'h20, 8'h20);
    apb(1'b1, `I2CS_OFF_CTRL, 32'hc5);
    if (last) begin
      apb(1'b1, `I2CS_OFF_STAT, 32'h01);
    end
    apb(1'b0, `I2CS_OFF_DATA, 32'h0);
    check(q[7:0], e);
    wait_oe(1'b0);
    rdc(`I2CS_OFF_STAT, 8'h20, 8'h00);
  endtask
  task automatic end_stop(input logic [7:0] e);
    u_i2cs_mst.stop();
    repeat (10) @(posedge pclk);
    rdc(`I2CS_OFF_CTRL, 8'h22, e);
    rdc(`I2CS_OFF_STAT, 8'h80, 8'h80);
    apb(1'b1, `I2CS_OFF_STAT, 32'h0);
    apb(1'b1, `I2CS_OFF_CTRL, 32'hc5);
  endtask
  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    seed = 32'h2781;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    bad_count = 0;
    check_count = 0;
    own = 7'h08 + 7'($random(seed) & 32'h3f);
    for (int i = 0; i < 4; i++) begin
      dat[i] = 8'($random(seed));
    end
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`I2CS_OFF_CTRL, 8'hff, 8'h00);
    apb(1'b0, 8'h20, 32'h0);
    check({7'h0, err}, 8'h01);
    apb(1'b1, `I2CS_OFF_OWN, {24'h0, own, 1'b0});
    apb(1'b1, `I2CS_OFF_OWN2, 32'h01);
    apb(1'b1, `I2CS_OFF_XCTL, 32'h01);
    apb(1'b1, `I2CS_OFF_CTRL, 32'hc5);
    u_i2cs_mst.glitch();
    repeat (20) @(posedge pclk);
    rdc(`I2CS_OFF_CTRL, 8'h20, 8'h00);
    $display("Test glitch done");
    u_i2cs_mst.start();
    rdc(`I2CS_OFF_CTRL, 8'h20, 8'h20);
    u_i2cs_mst.xfer_byte({own ^ 7'h01, 1'b0}, 1'b1, r, ack);
    check({7'h0, ack}, 8'h01);
    u_i2cs_mst.xfer_byte(8'h00, 1'b1, r, ack);
    check({7'h0, ack}, 8'h01);
    rdc(`I2CS_OFF_STAT, 8'h20, 8'h00);
    end_stop(8'h00);
    apb(1'b1, `I2CS_OFF_XCTL, 32'h0);
    $display("Test mismatch done");
    nb = 2 + ($random(seed) & 32'h1);
    u_i2cs_mst.start();
    fork
      begin
        u_i2cs_mst.xfer_byte({own, 1'b0}, 1'b1, r, ack);
        check({7'h0, ack}, 8'h00);
        for (int i = 0; i < nb; i++) begin
          u_i2cs_mst.xfer_byte(dat[i], 1'b1, r, ack);
          check({7'h0, ack}, {7'h0, i == nb - 1});
        end
      end
      begin
        serve_rx({own, 1'b0}, 1'b0);
        for (int j = 0; j < nb; j++) begin
          serve_rx(dat[j], j == nb - 2);
        end
      end
    join
    end_stop(8'h02);
    $display("Test receive done");
    d0 = dat[2];
    d1 = dat[3];
    apb(1'b1, `I2CS_OFF_MODE, 32'h08);
    rdc(`I2CS_OFF_MODE, 8'hff, 8'h08);
    u_i2cs_mst.start();
    fork
      begin
        u_i2cs_mst.xfer_byte({own, 1'b1}, 1'b1, r, ack);
        check({7'h0, ack}, 8'h00);
        u_i2cs_mst.xfer_byte(8'hff, 1'b0, r, ack);
        check(r, rev(d0));
        u_i2cs_mst.xfer_byte(8'hff, 1'b1, r, ack);
        check(r, rev(d1));
      end
      begin
        wait_oe(1'b1);
        rdc(`I2CS_OFF_CTRL, 8'h0a, 8'h0a);
        rdc(`I2CS_OFF_STAT, 8'h10, 8'h10);
        apb(1'b1, `I2CS_OFF_CTRL, 32'hcd);
        apb(1'b1, `I2CS_OFF_DATA, {24'h0, d0});
        wait_oe(1'b0);
        rdc(`I2CS_OFF_STAT, 8'h10, 8'h10);
        apb(1'b1, `I2CS_OFF_CTRL, 32'hcd);
        wait_oe(1'b1);
        rdc(`I2CS_OFF_STAT, 8'h01, 8'h00);
        apb(1'b1, `I2CS_OFF_DATA, {24'h0, d1});
        wait_oe(1'b0);
        apb(1'b1, `I2CS_OFF_CTRL, 32'hcd);
        wait_oe(1'b1);
        rdc(`I2CS_OFF_STAT, 8'h01, 8'h01);
        apb(1'b1, `I2CS_OFF_CTRL, 32'hc9);
        rdc(`I2CS_OFF_STAT, 8'h01, 8'h00);
        apb(1'b1, `I2CS_OFF_CTRL, 32'hc1);
        apb(1'b0, `I2CS_OFF_DATA, 32'h0);
        wait_oe(1'b0);
      end
    join
    end_stop(8'h02);
    $display("Test transmit done");
    u_i2cs_mst.start();
    fork
      u_i2cs_mst.xfer_byte({own, 1'b0}, 1'b1, r, ack);
      begin
        wait_oe(1'b1);
        apb(1'b1, `I2CS_OFF_CLR, {28'h0, `I2CS_CLR_CODE});
        repeat (2) @(posedge pclk);
        check({6'h0, scl_oe, sda_oe}, 8'h00);
        rdc(`I2CS_OFF_CLR, 8'hff, 8'h00);
        rdc(`I2CS_OFF_STAT, 8'h20, 8'h00);
        rdc(`I2CS_OFF_OWN, 8'hfe, {own, 1'b0});
        rdc(`I2CS_OFF_CTRL, 8'h22, 8'h22);
        apb(1'b1, `I2CS_OFF_CTRL, 32'hc4);
        repeat (80) @(posedge pclk);
        apb(1'b1, `I2CS_OFF_CLR, {28'h0, `I2CS_CLR_CODE});
      end
    join
    end_stop(8'h02);
    $display("Test clear done");
    tally_and_finish();
  end
endmodule
